// *** ssre_regs.svh ***
`ifndef SSRE_REGS_SVH
`define SSRE_REGS_SVH

// register byte offsets on the plain register port
`define SSRE_CTRL_OFS      8'h00
`define SSRE_BANK_OFS      8'h04
`define SSRE_ACC_OFS       8'h08
`define SSRE_STATUS_OFS    8'h0c
`define SSRE_PEEK_ADDR_OFS 8'h10
`define SSRE_PEEK_DATA_OFS 8'h14

// control field positions
`define SSRE_CTRL_EXT_BIT  0
`define SSRE_CTRL_WDT_BIT  1

// status field positions
`define SSRE_ST_PD_BIT     0
`define SSRE_ST_TO_BIT     1
`define SSRE_ST_SLEEP_BIT  2
`define SSRE_ST_Z_BIT      3
`define SSRE_ST_N_BIT      4

// reset values
`define SSRE_CTRL_RST      2'h0
`define SSRE_BANK_RST      4'h0
`define SSRE_ACC_RST       8'h00

// addressing constants and the set-all-ones fill value
`define SSRE_IDX_LIMIT     8'h5f
`define SSRE_ACC_SPLIT     8'h80
`define SSRE_ALL_ONES      8'hff

// watchdog timing defaults: counter period in core clock cycles, postscaler in counter periods
`define SSRE_WDT_TICKS     256
`define SSRE_POST_TICKS    16

`endif

// *** ssre_pkg.sv ***
package ssre_pkg;

	typedef enum logic [1:0] {
		SSRE_OP_NOP    = 2'b00,
		SSRE_OP_ROTATE = 2'b01,
		SSRE_OP_SET_ALL_ONES_OP   = 2'b10,
		SSRE_OP_SLEEP  = 2'b11
	} ssre_op_e;

	typedef struct packed {
		ssre_op_e   op;
		logic [7:0] f;
		logic       d;
		logic       a;
	} ssre_instr_s;

	typedef enum logic {
		SSRE_ST_RUN   = 1'b0,
		SSRE_ST_SLEEP = 1'b1
	} ssre_pwr_e;

endpackage

// *** ssre_core.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ssre_regs.svh"

module ssre_core #(
	parameter int BANK_W     = 4,
	parameter int WDT_TICKS  = `SSRE_WDT_TICKS,
	parameter int POST_TICKS = `SSRE_POST_TICKS
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire logic [7:0]           bus_addr,
	input  wire logic [31:0]          bus_wdata,
	input  wire logic                 bus_wr,
	input  wire logic                 bus_rd,
	output logic [31:0]               bus_rdata,
	input  wire logic                 instr_valid,
	input  wire ssre_pkg::ssre_instr_s instr,
	output logic                      instr_ready,
	input  wire logic [BANK_W+7:0]    index_base,
	input  wire logic                 wake_req,
	output logic                      osc_run,
	output logic                      sleeping,
	output logic                      wdt_expire,
	output logic                      file_wr_pulse,
	output logic [BANK_W+7:0]         file_wr_addr,
	output logic [7:0]                file_wr_data
);

	localparam int AW = BANK_W + 8;
	localparam int CW = $clog2(WDT_TICKS + 1);
	localparam int PW = $clog2(POST_TICKS + 1);
	localparam logic [CW-1:0] CNT_LAST = CW'(WDT_TICKS - 1);
	localparam logic [PW-1:0] POST_LAST = PW'(POST_TICKS - 1);

	// the logic serves at most sixteen banks and a counter of at least two steps
	if (BANK_W < 1 || BANK_W > 4 || WDT_TICKS < 2 || POST_TICKS < 1) begin : g_chk
		$error("ssre_core: unsupported parameter values");
	end

	logic [7:0]              file_mem [0:(1<<AW)-1];
	logic [1:0]              ctrl_r;
	logic [BANK_W-1:0]       bank_select_reg_r;
	logic [7:0]              acc_r;
	logic [AW-1:0]           peek_addr_r;
	logic                    power_down_flag_r;
	logic                    expiry_flag_r;
	logic                    zero_flag_r;
	logic                    neg_flag_r;
	logic [CW-1:0]           watchdog_counter_r;
	logic [PW-1:0]           post_r;
	logic [31:0]             rdata_r;
	logic                    wdt_expire_r;
	logic                    file_wr_pulse_r;
	logic [AW-1:0]           file_wr_addr_r;
	logic [7:0]              file_wr_data_r;
	ssre_pkg::ssre_pwr_e     pwr_r;
	ssre_pkg::ssre_pwr_e     pwr_nxt;

	logic                    take;
	logic                    do_rot;
	logic                    do_set_all_ones_op;
	logic                    do_sleep;
	logic [AW-1:0]           eff_addr;
	logic [7:0]              rot_res;
	logic                    tmo;
	logic                    ext_en;
	logic                    wdt_en;

	// effective file address from operand, bank bit, extension and bank select
	function automatic logic [AW-1:0] calc_addr(input logic [7:0] f, input logic a,
			input logic ext, input logic [BANK_W-1:0] bank_select_reg, input logic [AW-1:0] base);
		logic [AW-1:0] r;
		r = '0;
		if (!a && ext && f <= `SSRE_IDX_LIMIT) begin
			r = AW'(base + AW'(f));
		end else if (!a) begin
			// low half of the access bank is bank zero, high half the top bank
			r = (f < `SSRE_ACC_SPLIT) ? {{BANK_W{1'b0}}, f} : {{BANK_W{1'b1}}, f};
		end else begin
			r = {bank_select_reg, f};
		end
		return r;
	endfunction

	assign ext_en      = ctrl_r[`SSRE_CTRL_EXT_BIT];
	assign wdt_en      = ctrl_r[`SSRE_CTRL_WDT_BIT];
	// the core is stalled while asleep, so no instruction is taken then
	assign instr_ready = (pwr_r == ssre_pkg::SSRE_ST_RUN);
	assign take        = instr_valid && instr_ready;
	assign do_rot      = take && instr.op == ssre_pkg::SSRE_OP_ROTATE;
	assign do_set_all_ones_op     = take && instr.op == ssre_pkg::SSRE_OP_SET_ALL_ONES_OP;
	assign do_sleep    = take && instr.op == ssre_pkg::SSRE_OP_SLEEP;
	assign eff_addr    = calc_addr(instr.f, instr.a, ext_en, bank_select_reg_r, index_base);
	assign rot_res     = {file_mem[eff_addr][0], file_mem[eff_addr][7:1]};
	// the power-down instruction clears the counter, so it masks a time-out that cycle
	assign tmo = wdt_en && !do_sleep && watchdog_counter_r == CNT_LAST && post_r == POST_LAST;

	assign osc_run       = (pwr_r == ssre_pkg::SSRE_ST_RUN);
	assign sleeping      = (pwr_r == ssre_pkg::SSRE_ST_SLEEP);
	assign bus_rdata     = rdata_r;
	assign wdt_expire    = wdt_expire_r;
	assign file_wr_pulse = file_wr_pulse_r;
	assign file_wr_addr  = file_wr_addr_r;
	assign file_wr_data  = file_wr_data_r;

	// file memory: instructions first, bus pokes only when no instruction writes
	always_ff @(posedge core_clk) begin
		if (do_set_all_ones_op) begin
			file_mem[eff_addr] <= `SSRE_ALL_ONES;
		end else if (do_rot && instr.d) begin
			file_mem[eff_addr] <= rot_res;
		end else if (bus_wr && bus_addr == `SSRE_PEEK_DATA_OFS) begin
			file_mem[peek_addr_r] <= bus_wdata[7:0];
		end
	end

	// registered echo of each instruction write, for the core's write-back observers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			file_wr_pulse_r <= 1'b0;
			file_wr_addr_r  <= '0;
			file_wr_data_r  <= 8'h00;
		end else begin
			file_wr_pulse_r <= do_set_all_ones_op || (do_rot && instr.d);
			if (do_set_all_ones_op || (do_rot && instr.d)) begin
				file_wr_addr_r <= eff_addr;
				file_wr_data_r <= do_set_all_ones_op ? `SSRE_ALL_ONES : rot_res;
			end
		end
	end

	// accumulator: instruction result wins over a software write in the same cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			acc_r <= `SSRE_ACC_RST;
		end else if (do_rot && !instr.d) begin
			acc_r <= rot_res;
		end else if (bus_wr && bus_addr == `SSRE_ACC_OFS) begin
			acc_r <= bus_wdata[7:0];
		end
	end

	// negative and zero follow the rotate only; set-all-ones leaves them alone
	always_ff @(posedge core_clk) begin
		if (rst) begin
			zero_flag_r <= 1'b0;
			neg_flag_r  <= 1'b0;
		end else if (do_rot) begin
			zero_flag_r <= (rot_res == 8'h00);
			neg_flag_r  <= rot_res[7];
		end
	end

	// software control registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_r            <= `SSRE_CTRL_RST;
			bank_select_reg_r <= BANK_W'(`SSRE_BANK_RST);
			peek_addr_r       <= '0;
		end else if (bus_wr) begin
			if (bus_addr == `SSRE_CTRL_OFS) begin
				ctrl_r <= bus_wdata[1:0];
			end
			if (bus_addr == `SSRE_BANK_OFS) begin
				bank_select_reg_r <= bus_wdata[BANK_W-1:0];
			end
			if (bus_addr == `SSRE_PEEK_ADDR_OFS) begin
				peek_addr_r <= bus_wdata[AW-1:0];
			end
		end
	end

	// watchdog counter and postscaler
	always_ff @(posedge core_clk) begin
		if (rst) begin
			watchdog_counter_r <= '0;
			post_r             <= '0;
			wdt_expire_r       <= 1'b0;
		end else begin
			wdt_expire_r <= tmo;
			if (do_sleep) begin
				watchdog_counter_r <= '0;
				post_r             <= '0;
			end else if (wdt_en) begin
				if (watchdog_counter_r == CNT_LAST) begin
					watchdog_counter_r <= '0;
					post_r <= (post_r == POST_LAST) ? '0 : PW'(post_r + 1'b1);
				end else begin
					watchdog_counter_r <= CW'(watchdog_counter_r + 1'b1);
				end
			end
		end
	end

	// power-down and expiry flags both reset to one, active-low in sense
	always_ff @(posedge core_clk) begin
		if (rst) begin
			power_down_flag_r <= 1'b1;
			expiry_flag_r     <= 1'b1;
		end else begin
			if (do_sleep) begin
				power_down_flag_r <= 1'b0;
			end
			if (do_sleep) begin
				expiry_flag_r <= 1'b1;
			end else if (tmo) begin
				expiry_flag_r <= 1'b0;
			end
		end
	end

	// run/sleep state: a time-out or an external wake ends sleep
	always_comb begin
		pwr_nxt = pwr_r;
		unique case (pwr_r)
			ssre_pkg::SSRE_ST_RUN: begin
				if (do_sleep) begin
					pwr_nxt = ssre_pkg::SSRE_ST_SLEEP;
				end
			end
			ssre_pkg::SSRE_ST_SLEEP: begin
				if (tmo || wake_req) begin
					pwr_nxt = ssre_pkg::SSRE_ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pwr_r <= ssre_pkg::SSRE_ST_RUN;
		end else begin
			pwr_r <= pwr_nxt;
		end
	end

	// read port: data one cycle after the strobe, unmapped offsets read zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata_r <= 32'h0000_0000;
		end else if (bus_rd) begin
			unique case (bus_addr)
				`SSRE_CTRL_OFS:      rdata_r <= {30'h0, ctrl_r};
				`SSRE_BANK_OFS:      rdata_r <= 32'(bank_select_reg_r);
				`SSRE_ACC_OFS:       rdata_r <= {24'h0, acc_r};
				`SSRE_STATUS_OFS:    rdata_r <= {27'h0, neg_flag_r, zero_flag_r, sleeping,
				                                 expiry_flag_r, power_down_flag_r};
				`SSRE_PEEK_ADDR_OFS: rdata_r <= 32'(peek_addr_r);
				`SSRE_PEEK_DATA_OFS: rdata_r <= {24'h0, file_mem[peek_addr_r]};
				default:             rdata_r <= 32'h0000_0000;
			endcase
		end else begin
			rdata_r <= 32'h0000_0000;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	index_addr_a: assert property (do_set_all_ones_op && !instr.a && ext_en && instr.f <= 8'h5f
		|=> file_wr_addr == $past(index_base) + AW'($past(instr.f)))
		else $error("indexed offset address wrong");
	pd_clear_a: assert property (do_sleep |=> !power_down_flag_r)
		else $error("power-down flag not cleared");
	to_set_a: assert property (do_sleep |=> expiry_flag_r)
		else $error("expiry flag not set");
	wdt_clear_a: assert property (do_sleep |=> watchdog_counter_r == '0 && post_r == '0)
		else $error("watchdog not cleared");
	sleep_enter_a: assert property (do_sleep && !wake_req |=> !osc_run && !instr_ready)
		else $error("did not enter sleep");
	wake_tmo_a: assert property (sleeping && tmo |=> !expiry_flag_r && osc_run)
		else $error("time-out wake did not clear expiry flag");
	set_all_ones_op_ones_a: assert property (do_set_all_ones_op |=> file_wr_pulse && file_wr_data == 8'hff
		&& $stable(zero_flag_r) && $stable(neg_flag_r))
		else $error("set-all-ones wrong value or flags changed");
	rot_value_a: assert property (do_rot && instr.d
		|=> file_wr_data == {$past(file_mem[eff_addr][0]), $past(file_mem[eff_addr][7:1])})
		else $error("rotate result wrong");
	dest_acc_a: assert property (do_rot && !instr.d |=> acc_r == $past(rot_res)
		&& !file_wr_pulse)
		else $error("accumulator destination wrong");
	bank_sel_a: assert property (do_set_all_ones_op && instr.a
		|=> file_wr_addr == {$past(bank_select_reg_r), $past(instr.f)})
		else $error("bank select address wrong");

	sleep_wake_c: cover property (do_sleep ##[1:1000] (sleeping && tmo));
	ext_wake_c: cover property (sleeping && wake_req);
	index_set_all_ones_op_c: cover property (do_set_all_ones_op && !instr.a && ext_en && instr.f <= 8'h5f);
	rot_acc_c: cover property (do_rot && !instr.d);

endmodule

`default_nettype wire

// *** test_set_all_ones_op_sleep_rotate_exec.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "ssre_regs.svh"

module test_set_all_ones_op_sleep_rotate_exec;
	localparam int WT = 4;
	localparam int PT = 2;
	logic                  core_clk;
	logic                  rst;
	logic                  bus_wr;
	logic                  bus_rd;
	logic                  instr_valid;
	logic                  wake_req;
	logic [7:0]            bus_addr;
	logic [31:0]           bus_wdata;
	logic [31:0]           bus_rdata;
	ssre_pkg::ssre_instr_s instr;
	logic [11:0]           index_base;
	logic [11:0]           file_wr_addr;
	logic                  instr_ready;
	logic                  osc_run;
	logic                  sleeping;
	logic                  wdt_expire;
	logic                  file_wr_pulse;
	logic [7:0]            file_wr_data;
	logic [7:0]            v;
	logic [7:0]            f;
	logic [7:0]            r;
	logic [3:0]            bk;
	logic [11:0]           ad;
	logic                  a;
	logic                  ext;
	logic                  n_f;
	logic                  z_f;
	logic [7:0]            cf [3] = '{8'h5f, 8'h60, 8'h80};
	int                    n_errors = 0;
	int                    total_checks = 0;
	int                    k;

	ssre_core #(.WDT_TICKS(WT), .POST_TICKS(PT)) u_ssre_core (
		.core_clk(core_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
		.index_base(index_base), .wake_req(wake_req), .osc_run(osc_run),
		.sleeping(sleeping), .wdt_expire(wdt_expire), .file_wr_pulse(file_wr_pulse),
		.file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data)
	);

	// free-running core clock, 10 ns period
	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected pin at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test;
		if (n_errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
		@(posedge core_clk);
		bus_wr <= 1'h1;
		bus_addr <= ofs;
		bus_wdata <= d;
		@(posedge core_clk);
		bus_wr <= 1'h0;
	endtask

	// read data only stands in the cycle after the strobe, so sample there
	task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
		@(posedge core_clk);
		bus_rd <= 1'h1;
		bus_addr <= ofs;
		@(posedge core_clk);
		bus_rd <= 1'h0;
		#1;
		chk_val(bus_rdata, exp);
	endtask

	task automatic ex(input ssre_pkg::ssre_op_e op, input logic [7:0] fa, input logic d,
			input logic aa);
		@(posedge core_clk);
		instr_valid <= 1'h1;
		instr <= '{op: op, f: fa, d: d, a: aa};
		@(posedge core_clk);
		instr_valid <= 1'h0;
		#1;
	endtask

	function automatic logic [11:0] ea(input logic [7:0] fa, input logic aa);
		if (aa) begin
			return {bk, fa};
		end
		if (ext && fa <= 8'h5f) begin
			return index_base + {4'h0, fa};
		end
		return (fa < 8'h80) ? {4'h0, fa} : {4'hf, fa};
	endfunction

	function automatic logic [31:0] st(input logic pd, input logic to, input logic sl);
		return {27'h0, n_f, z_f, sl, to, pd};
	endfunction

	// counts edges until the watchdog pulse; running out of the bound counts as a failure
	task automatic wait_expire(output int n);
		for (n = 0; n < 200 && wdt_expire !== 1'h1; n++) begin
			@(posedge core_clk);
			#1;
		end
		if (wdt_expire !== 1'h1) begin
			n_errors++;
		end
	endtask

	// main sequence: reset, addressing and rotate sweep, then power-down paths
	initial begin
		{rst, bus_wr, bus_rd, instr_valid, wake_req} = 5'h10;
		bus_addr = 8'h00;
		bus_wdata = 32'h0000_0000;
		index_base = 12'h000;
		instr = ssre_pkg::ssre_instr_s'(12'h000);
		{n_f, z_f} = 2'h0;
		k = $urandom(7835);
		repeat (10) @(posedge core_clk);
		rst <= 1'h0;
		rd(`SSRE_STATUS_OFS, st(1'h1, 1'h1, 1'h0));
		rd(8'h20, 32'h0);
		for (k = 0; k < 14; k++) begin
			v = (k == 0) ? 8'h00 : 8'($urandom);
			f = (k < 3) ? cf[k] : 8'($urandom);
			a = (k < 3) ? 1'h0 : 1'($urandom);
			ext = (k < 3) ? 1'h1 : 1'($urandom);
			bk = 4'($urandom);
			// new index base goes out on a clock edge like every other input
			@(posedge core_clk);
			index_base <= 12'($urandom);
			wr(`SSRE_CTRL_OFS, {31'h0, ext});
			wr(`SSRE_BANK_OFS, {28'h0, bk});
			ad = ea(f, a);
			wr(`SSRE_PEEK_ADDR_OFS, {20'h0, ad});
			wr(`SSRE_PEEK_DATA_OFS, {24'h0, v});
			r = {v[0], v[7:1]};
			ex(ssre_pkg::SSRE_OP_ROTATE, f, 1'h1, a);
			chk_pin(file_wr_pulse, 1'h1);
			chk_val({20'h0, file_wr_addr}, {20'h0, ad});
			chk_val({24'h0, file_wr_data}, {24'h0, r});
			r = {r[0], r[7:1]};
			ex(ssre_pkg::SSRE_OP_ROTATE, f, 1'h0, a);
			chk_pin(file_wr_pulse, 1'h0);
			rd(`SSRE_ACC_OFS, {24'h0, r});
			n_f = r[7];
			z_f = (r == 8'h00);
			ex(ssre_pkg::SSRE_OP_SET_ALL_ONES_OP, f, 1'h0, a);
			chk_pin(file_wr_pulse, 1'h1);
			chk_val({20'h0, file_wr_addr}, {20'h0, ad});
			chk_val({24'h0, file_wr_data}, 32'hff);
			rd(`SSRE_STATUS_OFS, st(1'h1, 1'h1, 1'h0));
			rd(`SSRE_PEEK_DATA_OFS, 32'hff);
		end
		wr(`SSRE_CTRL_OFS, 32'h0);
		ex(ssre_pkg::SSRE_OP_SLEEP, 8'h00, 1'h0, 1'h0);
		chk_pin(osc_run, 1'h0);
		chk_pin(instr_ready, 1'h0);
		ex(ssre_pkg::SSRE_OP_SET_ALL_ONES_OP, 8'h10, 1'h0, 1'h0);
		chk_pin(file_wr_pulse, 1'h0);
		rd(`SSRE_STATUS_OFS, st(1'h0, 1'h1, 1'h1));
		@(posedge core_clk);
		wake_req <= 1'h1;
		for (k = 0; k < 20 && osc_run !== 1'h1; k++) begin
			@(posedge core_clk);
			#1;
		end
		chk_pin(osc_run, 1'h1);
		// wake request drops on an edge; it is ignored once the core runs
		@(posedge core_clk);
		wake_req <= 1'h0;
		rd(`SSRE_STATUS_OFS, st(1'h0, 1'h1, 1'h0));
		// let the watchdog run part way so the clear on power-down matters
		wr(`SSRE_CTRL_OFS, 32'h2);
		repeat (3) @(posedge core_clk);
		ex(ssre_pkg::SSRE_OP_SLEEP, 8'h00, 1'h0, 1'h0);
		chk_pin(sleeping, 1'h1);
		wait_expire(k);
		chk_val(k, WT * PT);
		chk_pin(osc_run, 1'h1);
		rd(`SSRE_STATUS_OFS, st(1'h0, 1'h0, 1'h0));
		end_of_test();
	end
endmodule

`default_nettype wire
